// ==== include/ctc_pkg.sv ====
// Shared constants and carrier types of the control timer command logic.
package ctc_pkg;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned CH_NUM = 4;
    localparam int unsigned CMD_W = 3;
    localparam int unsigned EVACT_W = 3;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [CMD_W-1:0] CMD_NONE = 3'h0;
    localparam logic [CMD_W-1:0] CMD_RESTART_ACTION = 3'h1;
    localparam logic [CMD_W-1:0] CMD_STOP = 3'h2;
    localparam logic [EVACT_W-1:0] EVACT_OFF = 3'h0;
    localparam logic [EVACT_W-1:0] EVACT_RESTART_ACTION = 3'h1;
    localparam logic [EVACT_W-1:0] EVACT_STOP = 3'h3;
    localparam logic [EVACT_W-1:0] EVACT_START = 3'h3;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic DIR_RST = 1'b0;
    localparam logic SINGLE_RST = 1'b0;

    typedef enum logic [1:0] {
        CTC_OFF,
        CTC_STOPPED,
        CTC_RUNNING
    } ctc_state_e;

    typedef struct packed {
        logic dir_down_set;
        logic dir_down_clr;
        logic single_run_set;
        logic single_run_clr;
        logic [CMD_W-1:0] cmd;
    } ctc_ctrlb_s;

    typedef struct packed {
        logic [EVACT_W-1:0] input_event0_action;
        logic [EVACT_W-1:0] input_event1_action;
        logic restart_event_out_enable;
        logic wrap_event_out_enable;
    } ctc_event_control_reg_s;

    typedef struct packed {
        logic wrap_flag;
        logic restart_flag;
    } ctc_flags_s;
endpackage

// ==== core/ctc_sync.sv ====
// Two-stage synchroniser for signals entering from the bus clock domain.
`timescale 1ns/100ps
module ctc_sync #(
    parameter int unsigned W = 1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule

// ==== core/ctc_core.sv ====
// Counter control, commands, event actions and waveform outputs of the control timer.
`timescale 1ns/100ps
module ctc_core #(
    parameter int unsigned WIDTH = ctc_pkg::CNT_W,
    parameter int unsigned CHANNELS = ctc_pkg::CH_NUM
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic ctrlb_toggle_i,
    input wire ctc_pkg::ctc_ctrlb_s ctrlb_i,
    input wire logic count_wr_toggle_i,
    input wire logic [WIDTH-1:0] count_wr_data_i,
    input wire ctc_pkg::ctc_event_control_reg_s event_control_reg_i,
    input wire logic [WIDTH-1:0] period_i,
    input wire logic [CHANNELS-1:0][WIDTH-1:0] compare_i,
    input wire logic input_event0_i,
    input wire logic input_event1_i,
    input wire ctc_pkg::ctc_flags_s irq_flag_clr_i,
    input wire ctc_pkg::ctc_flags_s irq_enable_i,
    output logic [CHANNELS-1:0] waveform_out_o,
    output logic [WIDTH-1:0] count_o,
    output logic running_o,
    output logic dir_down_o,
    output logic single_run_flag_o,
    output logic [ctc_pkg::CMD_W-1:0] cmd_o,
    output logic ctrlb_ack_toggle_o,
    output logic count_wr_ack_toggle_o,
    output ctc_pkg::ctc_flags_s irq_flag_reg_o,
    output logic irq_o,
    output logic dma_req_o,
    output logic wrap_event_o,
    output logic restart_event_o
);
    logic enable_q;
    logic ctrlb_tgl_q;
    logic cnt_tgl_q;
    logic ctrlb_seen_r;
    logic cnt_seen_r;
    logic ctrlb_wr;
    logic cnt_wr;
    logic dir_down_r;
    logic single_run_r;
    logic [ctc_pkg::CMD_W-1:0] cmd_pend_r;
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    ctc_pkg::ctc_state_e state_r;
    ctc_pkg::ctc_state_e state_nxt;
    logic touched_r;
    logic wrap_hit;
    logic restart_hit;
    logic stop_req;
    logic retrig_req;
    logic start_req;
    logic retrig_cfg;
    logic at_limit;
    logic [WIDTH-1:0] start_val;
    logic [CHANNELS-1:0] wave_r;
    ctc_pkg::ctc_flags_s flags_r;
    logic wrap_evt_r;
    logic restart_evt_r;

    ctc_sync #(
        .W(3)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({enable_i, ctrlb_toggle_i, count_wr_toggle_i}),
        .q_o({enable_q, ctrlb_tgl_q, cnt_tgl_q})
    );

    assign ctrlb_wr = ctrlb_tgl_q ^ ctrlb_seen_r;
    assign cnt_wr = cnt_tgl_q ^ cnt_seen_r;

    // Acknowledge toggles follow the synchronised request toggles.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrlb_seen_r <= 1'b0;
            cnt_seen_r <= 1'b0;
        end else begin
            ctrlb_seen_r <= ctrlb_tgl_q;
            cnt_seen_r <= cnt_tgl_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dir_down_r <= ctc_pkg::DIR_RST;
            single_run_r <= ctc_pkg::SINGLE_RST;
        end else if (ctrlb_wr) begin
            if (ctrlb_i.dir_down_set) begin
                dir_down_r <= 1'b1;
            end else if (ctrlb_i.dir_down_clr) begin
                dir_down_r <= 1'b0;
            end
            if (ctrlb_i.single_run_set) begin
                single_run_r <= 1'b1;
            end else if (ctrlb_i.single_run_clr) begin
                single_run_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cmd_pend_r <= ctc_pkg::CMD_NONE;
        end else if (ctrlb_wr) begin
            cmd_pend_r <= ctrlb_i.cmd;
        end else begin
            cmd_pend_r <= ctc_pkg::CMD_NONE;
        end
    end

    always_comb begin
        stop_req = (cmd_pend_r == ctc_pkg::CMD_STOP);
        stop_req = stop_req || (input_event1_i &&
            event_control_reg_i.input_event1_action == ctc_pkg::EVACT_STOP);
        retrig_req = (cmd_pend_r == ctc_pkg::CMD_RESTART_ACTION) ||
            (input_event0_i &&
            event_control_reg_i.input_event0_action == ctc_pkg::EVACT_RESTART_ACTION) ||
            (input_event1_i &&
            event_control_reg_i.input_event1_action == ctc_pkg::EVACT_RESTART_ACTION);
        start_req = input_event0_i &&
            event_control_reg_i.input_event0_action == ctc_pkg::EVACT_START;
        retrig_cfg = event_control_reg_i.input_event0_action == ctc_pkg::EVACT_RESTART_ACTION ||
            event_control_reg_i.input_event1_action == ctc_pkg::EVACT_RESTART_ACTION;
        start_val = dir_down_r ? period_i : ctc_pkg::COUNT_RST;
        at_limit = dir_down_r ? (count_r == ctc_pkg::COUNT_RST) : (count_r == period_i);
    end

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        wrap_hit = 1'b0;
        restart_hit = 1'b0;
        if (!enable_q) begin
            state_nxt = ctc_pkg::CTC_OFF;
        end else begin
            unique case (state_r)
                ctc_pkg::CTC_OFF: begin
                    state_nxt = retrig_cfg ? ctc_pkg::CTC_STOPPED : ctc_pkg::CTC_RUNNING;
                    if (!touched_r) begin
                        count_nxt = start_val;
                    end
                end
                ctc_pkg::CTC_STOPPED: begin
                    if (retrig_req || start_req) begin
                        state_nxt = ctc_pkg::CTC_RUNNING;
                    end
                end
                ctc_pkg::CTC_RUNNING: begin
                    if (stop_req) begin
                        state_nxt = ctc_pkg::CTC_STOPPED;
                    end else if (retrig_req) begin
                        count_nxt = start_val;
                        restart_hit = 1'b1;
                    end else if (at_limit) begin
                        wrap_hit = 1'b1;
                        if (single_run_r) begin
                            state_nxt = ctc_pkg::CTC_STOPPED;
                        end else begin
                            count_nxt = start_val;
                        end
                    end else if (dir_down_r) begin
                        count_nxt = count_r - ctc_pkg::COUNT_ONE;
                    end else begin
                        count_nxt = count_r + ctc_pkg::COUNT_ONE;
                    end
                end
            endcase
        end
        if (cnt_wr) begin
            count_nxt = count_wr_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= ctc_pkg::CTC_OFF;
            count_r <= ctc_pkg::COUNT_RST;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    // remember a written or stopped-elsewhere value
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            touched_r <= 1'b0;
        end else if (cnt_wr) begin
            touched_r <= 1'b1;
        end else if (state_r == ctc_pkg::CTC_OFF && enable_q) begin
            touched_r <= 1'b0;
        end else if (state_r != ctc_pkg::CTC_OFF && state_nxt == ctc_pkg::CTC_OFF) begin
            touched_r <= (count_r != ctc_pkg::COUNT_RST);
        end
    end

    for (genvar n = 0; n < CHANNELS; n++) begin : g_wave
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                wave_r[n] <= 1'b0;
            end else begin
                wave_r[n] <= (state_r != ctc_pkg::CTC_OFF) && (count_r < compare_i[n]);
            end
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_r <= '0;
        end else begin
            flags_r.wrap_flag <= wrap_hit || (flags_r.wrap_flag && !irq_flag_clr_i.wrap_flag);
            flags_r.restart_flag <= restart_hit ||
                (flags_r.restart_flag && !irq_flag_clr_i.restart_flag);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wrap_evt_r <= 1'b0;
            restart_evt_r <= 1'b0;
        end else begin
            wrap_evt_r <= wrap_hit && event_control_reg_i.wrap_event_out_enable;
            restart_evt_r <= restart_hit && event_control_reg_i.restart_event_out_enable;
        end
    end

    assign waveform_out_o = wave_r;
    assign count_o = count_r;
    assign running_o = (state_r == ctc_pkg::CTC_RUNNING);
    assign dir_down_o = dir_down_r;
    assign single_run_flag_o = single_run_r;
    assign cmd_o = cmd_pend_r;
    assign ctrlb_ack_toggle_o = ctrlb_seen_r;
    assign count_wr_ack_toggle_o = cnt_seen_r;
    assign irq_flag_reg_o = flags_r;
    assign irq_o = |(flags_r & irq_enable_i);
    assign dma_req_o = flags_r.wrap_flag;
    assign wrap_event_o = wrap_evt_r;
    assign restart_event_o = restart_evt_r;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    cnt_write_prio_a: assert property (cnt_wr |=> count_r == $past(count_wr_data_i))
        else $error("Count write lost to counting.");
    stop_cmd_a: assert property (
        running_o && cmd_pend_r == ctc_pkg::CMD_STOP && !cnt_wr && enable_q
        |=> state_r == ctc_pkg::CTC_STOPPED)
        else $error("Stop command did not stop.");
    ev1_pause_a: assert property (
        running_o && input_event1_i && enable_q &&
        event_control_reg_i.input_event1_action == ctc_pkg::EVACT_STOP
        |=> !running_o)
        else $error("Pause event did not stop.");
    retrig_flag_a: assert property (
        running_o && retrig_req && !stop_req && enable_q
        |=> irq_flag_reg_o.restart_flag)
        else $error("Restart_action flag not set.");
    retrig_event_a: assert property (
        restart_hit && event_control_reg_i.restart_event_out_enable ##1 !restart_hit
        |-> restart_event_o ##1 !restart_event_o)
        else $error("Restart_action event missing.");
    resume_hold_a: assert property (
        state_r == ctc_pkg::CTC_STOPPED && retrig_req && enable_q && !cnt_wr
        |=> running_o && $stable(count_r))
        else $error("Resume did not keep count.");
    single_stop_a: assert property (
        running_o && wrap_hit && single_run_r && !cnt_wr && enable_q
        |=> !running_o && irq_flag_reg_o.wrap_flag)
        else $error("Single run kept counting.");
    cmd_clear_a: assert property (
        cmd_pend_r != ctc_pkg::CMD_NONE && !ctrlb_wr |=> cmd_o == ctc_pkg::CMD_NONE)
        else $error("Command field not cleared.");
    start_ev0_a: assert property (
        state_r == ctc_pkg::CTC_STOPPED && start_req && enable_q |=> running_o)
        else $error("Start event ignored.");
    wrap_irq_a: assert property (
        wrap_hit ##1 irq_enable_i.wrap_flag |-> irq_o && dma_req_o)
        else $error("Wrap did not raise requests.");
    en_wait_a: assert property (
        state_r == ctc_pkg::CTC_OFF && enable_q && retrig_cfg |=> !running_o)
        else $error("Enable started with restart_action action.");
    wave_off_a: assert property (
        state_r == ctc_pkg::CTC_OFF |=> waveform_out_o == '0)
        else $error("Waveform active while off.");
    start_up_a: assert property (
        state_r == ctc_pkg::CTC_OFF && enable_q && !touched_r && !cnt_wr && !dir_down_r
        |=> count_r == ctc_pkg::COUNT_RST)
        else $error("Start value not zero.");
    start_down_a: assert property (
        state_r == ctc_pkg::CTC_OFF && enable_q && !touched_r && !cnt_wr && dir_down_r
        |=> count_r == $past(period_i))
        else $error("Start value not limit.");
    dir_set_a: assert property (
        ctrlb_wr && ctrlb_i.dir_down_set |=> dir_down_o)
        else $error("Direction set lost.");
    ev_retrig_a: assert property (
        running_o && enable_q && !stop_req && input_event0_i &&
        event_control_reg_i.input_event0_action == ctc_pkg::EVACT_RESTART_ACTION
        |=> irq_flag_reg_o.restart_flag)
        else $error("Event restart_action ignored.");

    wrap_seen_c: cover property (running_o && wrap_hit);
    retrig_seen_c: cover property (running_o && restart_hit);
    resume_seen_c: cover property (state_r == ctc_pkg::CTC_STOPPED ##1 running_o);
    write_run_c: cover property (running_o && cnt_wr);
endmodule

// ==== verification/ctc_host_model.sv ====
// Software register writer that drives the toggle handshakes into the timer.
`timescale 1ns/100ps
module ctc_host_model (
    input wire logic mclk_i,
    input wire logic ctrlb_ack_toggle_i,
    input wire logic count_wr_ack_toggle_i,
    output logic ctrlb_toggle_o,
    output ctc_pkg::ctc_ctrlb_s ctrlb_o,
    output logic count_wr_toggle_o,
    output logic [ctc_pkg::CNT_W-1:0] count_wr_data_o
);
    initial begin
        ctrlb_toggle_o = 1'b0;
        ctrlb_o = '0;
        count_wr_toggle_o = 1'b0;
        count_wr_data_o = '0;
    end
    task automatic ctrlb_write(input ctc_pkg::ctc_ctrlb_s v);
        @(negedge mclk_i);
        ctrlb_o = v;
        ctrlb_toggle_o = ~ctrlb_toggle_o;
        for (int i = 0; i < 20 && ctrlb_ack_toggle_i !== ctrlb_toggle_o; i++) @(negedge mclk_i);
        ctrlb_o = ~v;
    endtask
    task automatic count_write(input logic [ctc_pkg::CNT_W-1:0] d);
        @(negedge mclk_i);
        count_wr_data_o = d;
        count_wr_toggle_o = ~count_wr_toggle_o;
        for (int i = 0; i < 20 && count_wr_ack_toggle_i !== count_wr_toggle_o; i++) begin
            @(negedge mclk_i);
        end
        count_wr_data_o = ~d;
    endtask
endmodule

// ==== verification/control_timer_command_logic_tb.sv ====
// Self-checking testbench of the control timer command logic.
`timescale 1ns/100ps
module control_timer_command_logic_tb;
    logic mclk_i, rst_i, enable_i, ev0, ev1, ctb, cwt, cba, cwa, run, dd, sr, irq, dma, we, re;
    ctc_pkg::ctc_ctrlb_s cb;
    ctc_pkg::ctc_event_control_reg_s evc;
    ctc_pkg::ctc_flags_s fclr, fen, fl;
    logic [15:0] cwd, period, cnt, c1;
    logic [3:0][15:0] cmp;
    logic [3:0] wo;
    logic [2:0] cmd;
    int failures = 0;
    int comparisons = 0;
    logic [31:0] rows [4] = '{32'h1234_1234, 32'hffff_ffff, 32'h00ff_00ff, 32'h0000_0000};

    ctc_host_model u_ctc_host_model (.mclk_i(mclk_i), .ctrlb_ack_toggle_i(cba),
        .count_wr_ack_toggle_i(cwa), .ctrlb_toggle_o(ctb), .ctrlb_o(cb),
        .count_wr_toggle_o(cwt), .count_wr_data_o(cwd));
    ctc_core u_ctc_core (.mclk_i(mclk_i), .rst_i(rst_i), .enable_i(enable_i),
        .ctrlb_toggle_i(ctb), .ctrlb_i(cb), .count_wr_toggle_i(cwt), .count_wr_data_i(cwd),
        .event_control_reg_i(evc), .period_i(period), .compare_i(cmp), .input_event0_i(ev0),
        .input_event1_i(ev1), .irq_flag_clr_i(fclr), .irq_enable_i(fen), .waveform_out_o(wo),
        .count_o(cnt), .running_o(run), .dir_down_o(dd), .single_run_flag_o(sr), .cmd_o(cmd),
        .ctrlb_ack_toggle_o(cba), .count_wr_ack_toggle_o(cwa), .irq_flag_reg_o(fl),
        .irq_o(irq), .dma_req_o(dma), .wrap_event_o(we), .restart_event_o(re));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_run(input logic v);
        for (int i = 0; i < 40 && run !== v; i++) @(negedge mclk_i);
    endtask
    task automatic pulse(input logic which);
        if (which) ev1 = 1'b1;
        else ev0 = 1'b1;
        @(negedge mclk_i);
        if (which) ev1 = 1'b0;
        else ev0 = 1'b0;
    endtask
    task automatic wcb(input logic [6:0] v);
        u_ctc_host_model.ctrlb_write(v);
        check(cba, ctb); // Control write acknowledged.
        repeat (3) @(negedge mclk_i);
    endtask

    initial begin
        repeat (3000) @(posedge mclk_i);
        failures++;
        close_out();
    end

    initial begin
        rst_i = 1'b1;
        enable_i = 1'b0;
        ev0 = 1'b0;
        ev1 = 1'b0;
        evc = '0;
        fclr = '0;
        fen = '1;
        period = 16'h00ff;
        cmp = '0;
        cmp[0] = 16'hffff;
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        check(cnt, 32'h0); // Count starts at zero.
        check({run, fl}, 32'h0); // Timer is idle.
        $display("Test reset done");
        foreach (rows[i]) begin
            u_ctc_host_model.count_write(rows[i][31:16]);
            @(negedge mclk_i);
            check(cnt, rows[i][15:0]); // Written value is held.
            check(cwa, cwt); // Count write acknowledged.
        end
        $display("Test count writes done");
        enable_i = 1'b1;
        wait_run(1'b1);
        repeat (4) @(negedge mclk_i);
        c1 = cnt;
        @(negedge mclk_i);
        check(cnt, c1 + 16'h1); // Counter counts up.
        check(wo, 32'h1); // Outputs follow compares.
        evc.restart_event_out_enable = 1'b1;
        u_ctc_host_model.ctrlb_write({4'h0, ctc_pkg::CMD_RESTART_ACTION});
        for (int i = 0; i < 10 && re !== 1'b1; i++) @(negedge mclk_i);
        check({re, cnt}, 32'h1_0000); // Reload clears count.
        check({fl.restart_flag, irq}, 32'h3); // Flag and interrupt raised.
        check(cmd, 32'h0); // Command reads zero.
        fclr.restart_flag = 1'b1;
        @(negedge mclk_i);
        fclr.restart_flag = 1'b0;
        check(fl, 32'h0); // Flag clears on pulse.
        $display("Test restart_action done");
        wcb(7'h40);
        c1 = cnt;
        @(negedge mclk_i);
        check({dd, cnt}, {16'h1, c1 - 16'h1}); // Direction turns down.
        wcb(7'h20);
        wcb({4'h0, ctc_pkg::CMD_STOP});
        c1 = cnt;
        repeat (3) @(negedge mclk_i);
        check({run, cnt}, {16'h0, c1}); // Stop holds the count.
        wcb({4'h0, ctc_pkg::CMD_RESTART_ACTION});
        check({run, fl.restart_flag}, 32'h2); // Stopped counter resumes.
        check(32'(cnt - c1 < 16'h8), 32'h1); // Resumes from held value.
        $display("Test commands done");
        evc.input_event1_action = ctc_pkg::EVACT_STOP;
        evc.input_event0_action = ctc_pkg::EVACT_START;
        pulse(1'b1);
        wait_run(1'b0);
        check(run, 32'h0); // Event pauses counter.
        pulse(1'b0);
        wait_run(1'b1);
        check(run, 32'h1); // Event starts counter.
        enable_i = 1'b0;
        evc.input_event0_action = ctc_pkg::EVACT_RESTART_ACTION;
        evc.input_event1_action = ctc_pkg::EVACT_RESTART_ACTION;
        repeat (6) @(negedge mclk_i);
        enable_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        check(run, 32'h0); // Enable waits for event.
        pulse(1'b1);
        wait_run(1'b1);
        check(run, 32'h1); // Event retriggers counter.
        pulse(1'b0);
        check({fl.restart_flag, cnt}, 32'h1_0000); // Running event reloads count.
        $display("Test events done");
        evc = 8'h01;
        period = 16'h0010;
        fclr.wrap_flag = 1'b1;
        @(negedge mclk_i);
        fclr.wrap_flag = 1'b0;
        check({fl.wrap_flag, dma}, 32'h0); // No wrap yet.
        wcb(7'h10);
        wait_run(1'b0);
        check({sr, cnt}, 32'h1_0010); // Single run stops at limit.
        check({fl.wrap_flag, dma, irq}, 32'h7); // Wrap raises requests.
        check(we, 32'h1); // Wrap emits an event.
        fen = '0;
        @(negedge mclk_i);
        check({fl.wrap_flag, irq, we}, 32'h4); // Mask holds interrupt low.
        $display("Test single run done");
        rst_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        @(negedge mclk_i);
        check({run, sr, dd, fl, cnt}, 32'h0); // Reset returns to idle.
        wait_run(1'b1);
        check({run, cnt}, 32'h1_0000); // Restart counts from zero.
        $display("Test reset again done");
        close_out();
    end
endmodule
